// ---- rbs_map.svh ----
// Address map, reset values and step sizes of the register bank and stack check.
// Assumes 16-bit addresses inside the system segment and a word-organised
// dual-port RAM.
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH

// ****************************************************************
// System segment and memory areas
// ****************************************************************
`define RBS_SYS_SEG        8'h00
`define RBS_DUAL_PORT_RAM_BASE     16'hF600
`define RBS_DUAL_PORT_RAM_LAST     16'hFDFF
`define RBS_BITAREA_BASE   16'hFD00
`define RBS_SFR_BASE       16'hFE00
`define RBS_EXTENDED_FUNCTION_REGISTER_BASE      16'hF000
`define RBS_EXTENDED_FUNCTION_REGISTER_LAST      16'hF1FF

// ****************************************************************
// Pointer reset values and stack step
// ****************************************************************
`define RBS_RST_BANK_BASE  16'hFC00
`define RBS_RST_STACK_TOP  16'hFC00
`define RBS_RST_OVF_LIMIT  16'hFA00
`define RBS_RST_UNF_LIMIT  16'hFC00
`define RBS_STACK_STEP     16'h0002

`endif

// ---- rbs_pkg.sv ----
// Types shared by the register bank and stack check block.
// Assumes the core issues one access kind per request.
package rbs_pkg;

    // Access kinds issued by the core
    typedef enum logic [2:0] {
        ACC_REG_WORD = 3'h0,
        ACC_REG_BYTE = 3'h1,
        ACC_REG_BIT  = 3'h2,
        ACC_MEM_WORD = 3'h3,
        ACC_MEM_BYTE = 3'h4,
        ACC_MEM_BIT  = 3'h5,
        ACC_PUSH     = 3'h6,
        ACC_POP      = 3'h7
    } rbs_kind_t;

    // Pointer selected by a pointer write
    typedef enum logic [1:0] {
        PTR_BANK_BASE = 2'h0,
        PTR_STACK_TOP = 2'h1,
        PTR_OVF_LIMIT = 2'h2,
        PTR_UNF_LIMIT = 2'h3
    } rbs_ptr_t;

    // One-hot access sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_MOD  = 2'b10
    } rbs_state_t;

endpackage

// ---- rbs_dual_port_ram.sv ----
// Word-organised dual-port RAM: one write port, one read port.
// Assumes the caller never needs the data written in the same cycle.
`timescale 1ns/10ps

module rbs_dual_port_ram #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          srst,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rd_data_r;

    // Write port, no reset so it maps onto RAM cells
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_r;

endmodule

// ---- rbs_top.sv ----
// Register bank and stack check: maps general registers into the dual-port
// RAM through the bank base pointer, does bit access, and guards the stack.
// Assumes the core pipeline issues one access at a time while acc_ready is high.
//
// Notes on behaviour
// - A bank holds 16 word registers, the lower eight also split into low and high bytes.
// - The dual-port RAM holds user variables, stack and register banks side by side.
// - Every bit of the top 256 bytes of the dual-port RAM can be read and written singly.
// - A RAM word used as a general register is bit addressable through that register.
// - Every general register address is the bank base pointer plus the register offset.
// - Any number of banks of 16 words, copies limited only by the RAM space.
// - Banks may overlap so that shared registers pass parameters.
// - The stack holds up to 1024 words anywhere in the RAM and is addressed by the stack top pointer.
// - A push compares the lowered stack top pointer with the overflow limit, a pop the stack top pointer with the underflow limit.
// - The two function register areas are 512 bytes each and hold only word registers.
// - RAM and both function register areas lie in segment 0.
`timescale 1ns/10ps
`include "rbs_map.svh"

module rbs_top #(
    parameter int RAM_AW = 10
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              ptr_wr,
    input  wire rbs_pkg::rbs_ptr_t ptr_sel,
    input  wire logic [15:0]       ptr_wdata,
    input  wire logic              acc_req,
    input  wire rbs_pkg::rbs_kind_t acc_kind,
    input  wire logic              acc_wr,
    input  wire logic [3:0]        acc_reg_num,
    input  wire logic [23:0]       acc_addr,
    input  wire logic [3:0]        acc_bit,
    input  wire logic [15:0]       acc_wdata,
    output logic                   acc_ready,
    output logic                   rsp_valid,
    output logic [15:0]            rsp_rdata,
    output logic                   rsp_addr_err,
    output logic                   rsp_sfr_hit,
    output logic                   trap_stack_over,
    output logic                   trap_stack_under,
    output logic [15:0]            bank_base_pointer,
    output logic [15:0]            stack_top_pointer
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Byte lane pick, used on read only; the merge picks its lanes itself
    function automatic logic [7:0] rbs_lane(input logic [15:0] w, input logic hi);
        rbs_lane = hi ? w[15:8] : w[7:0];
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    rbs_pkg::rbs_state_t state_r;
    rbs_pkg::rbs_kind_t  kind_r;
    logic [15:0] bbp_r, sp_r, ovl_r, unl_r, sp_new_r, wdata_r, rsp_rdata_r;
    logic [RAM_AW-1:0] idx_r;
    logic [3:0]  bpos_r;
    logic        wr_r, hi_r, err_r, sfr_r, ovf_r, unf_r;
    logic        ready_r, rsp_valid_r, rsp_err_r, rsp_sfr_r, trap_ov_r, trap_un_r;

    // ****************************************************************
    // Address resolution of a new request
    // ****************************************************************
    logic        take, is_reg, is_mem, is_bit, is_byte, is_word, is_push, is_pop;
    logic        seg_ok, in_ram, in_bit, in_sfr, ovf_now, unf_now, err_now;
    logic [15:0] ea, ea_off, sp_dec;
    logic [RAM_AW-1:0] rd_idx;

    assign take    = acc_req && ready_r;
    assign is_reg  = acc_kind inside {rbs_pkg::ACC_REG_WORD, rbs_pkg::ACC_REG_BYTE,
                                      rbs_pkg::ACC_REG_BIT};
    assign is_mem  = acc_kind inside {rbs_pkg::ACC_MEM_WORD, rbs_pkg::ACC_MEM_BYTE,
                                      rbs_pkg::ACC_MEM_BIT};
    assign is_bit  = acc_kind inside {rbs_pkg::ACC_REG_BIT, rbs_pkg::ACC_MEM_BIT};
    assign is_byte = acc_kind inside {rbs_pkg::ACC_REG_BYTE, rbs_pkg::ACC_MEM_BYTE};
    assign is_push = acc_kind == rbs_pkg::ACC_PUSH;
    assign is_pop  = acc_kind == rbs_pkg::ACC_POP;
    assign is_word = !is_bit && !is_byte;
    assign sp_dec  = sp_r - `RBS_STACK_STEP;

    // base plus offset
    // Overlapping banks fall out of plain addition; no bank is private.
    // Byte register k lives in word register k>>1, so the step is one word, not two
    assign ea = (acc_kind == rbs_pkg::ACC_REG_BYTE) ? bbp_r + {12'h000, acc_reg_num[3:1], 1'b0}
              : is_reg  ? bbp_r + {11'h000, acc_reg_num, 1'b0}
              : is_push ? sp_dec
              : is_pop  ? sp_r
              : acc_addr[15:0];

    assign seg_ok = !is_mem || (acc_addr[23:16] == `RBS_SYS_SEG);
    assign in_ram = (ea >= `RBS_DUAL_PORT_RAM_BASE) && (ea <= `RBS_DUAL_PORT_RAM_LAST);
    assign in_bit = ea >= `RBS_BITAREA_BASE;
    assign in_sfr = (ea >= `RBS_SFR_BASE) || ((ea >= `RBS_EXTENDED_FUNCTION_REGISTER_BASE) && (ea <= `RBS_EXTENDED_FUNCTION_REGISTER_LAST));
    assign ovf_now = is_push && (sp_dec < ovl_r);
    assign unf_now = is_pop && (sp_r >= unl_r);
    // Odd word address, foreign segment, outside RAM or memory bit access outside bit area
    assign err_now = !seg_ok || !in_ram || (is_word && ea[0])
                   || ((acc_kind == rbs_pkg::ACC_MEM_BIT) && !in_bit);
    assign ea_off  = ea - `RBS_DUAL_PORT_RAM_BASE;
    assign rd_idx  = ea_off[RAM_AW:1];

    // ****************************************************************
    // Merge and answer of the access in flight
    // ****************************************************************
    logic        refused, ram_we;
    logic [15:0] ram_rdata, ram_wdata, bmask;
    logic [7:0]  old_lane;

    assign refused  = err_r || ovf_r || unf_r;
    assign ram_we   = (state_r == rbs_pkg::ST_MOD) && wr_r && !refused;
    assign old_lane = rbs_lane(ram_rdata, hi_r);
    assign bmask    = 16'h0001 << bpos_r;

    assign ram_wdata = (kind_r inside {rbs_pkg::ACC_REG_BYTE, rbs_pkg::ACC_MEM_BYTE})
                     ? (hi_r ? {wdata_r[7:0], ram_rdata[7:0]} : {ram_rdata[15:8], wdata_r[7:0]})
                     : (kind_r inside {rbs_pkg::ACC_REG_BIT, rbs_pkg::ACC_MEM_BIT})
                     ? (wdata_r[0] ? (ram_rdata | bmask) : (ram_rdata & ~bmask))
                     : wdata_r;

    rbs_dual_port_ram #(
        .AW (RAM_AW),
        .DW (16)
    ) u_ram (
        .clk_sys (clk_sys),
        .srst    (srst),
        .wr_en   (ram_we),
        .wr_addr (idx_r),
        .wr_data (ram_wdata),
        .rd_addr (rd_idx),
        .rd_data (ram_rdata)
    );

    // Request capture; read is already on its way to the RAM
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= rbs_pkg::ST_IDLE;
            ready_r <= 1'b1;
        end else if (take) begin
            state_r <= rbs_pkg::ST_MOD;
            ready_r <= 1'b0;
        end else begin
            state_r <= rbs_pkg::ST_IDLE;
            ready_r <= 1'b1;
        end
    end

    // Attributes of the access in flight
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            kind_r <= rbs_pkg::ACC_REG_WORD;
            {wr_r, hi_r, err_r, sfr_r, ovf_r, unf_r} <= 6'h00;
            {idx_r, bpos_r, wdata_r, sp_new_r} <= '0;
        end else if (take) begin
            kind_r   <= acc_kind;
            wr_r     <= acc_wr || is_push;
            hi_r     <= is_reg ? acc_reg_num[0] : ea[0];
            err_r    <= err_now;
            sfr_r    <= in_sfr;
            ovf_r    <= ovf_now;
            unf_r    <= unf_now;
            idx_r    <= rd_idx;
            bpos_r   <= (acc_kind == rbs_pkg::ACC_MEM_BIT) ? {ea[0], acc_bit[2:0]} : acc_bit;
            wdata_r  <= acc_wdata;
            sp_new_r <= is_push ? sp_dec : sp_r + `RBS_STACK_STEP;
        end
    end

    // trap with the answer
    // Answer is registered so the core sees it one cycle after the RAM read.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            {rsp_valid_r, rsp_err_r, rsp_sfr_r, trap_ov_r, trap_un_r} <= 5'h00;
            rsp_rdata_r <= 16'h0000;
        end else begin
            rsp_valid_r <= state_r == rbs_pkg::ST_MOD;
            rsp_err_r   <= (state_r == rbs_pkg::ST_MOD) && err_r;
            rsp_sfr_r   <= (state_r == rbs_pkg::ST_MOD) && sfr_r;
            trap_ov_r   <= (state_r == rbs_pkg::ST_MOD) && ovf_r;
            trap_un_r   <= (state_r == rbs_pkg::ST_MOD) && unf_r;
            if (state_r != rbs_pkg::ST_MOD || refused) begin
                rsp_rdata_r <= 16'h0000;
            end else if (kind_r inside {rbs_pkg::ACC_REG_BYTE, rbs_pkg::ACC_MEM_BYTE}) begin
                rsp_rdata_r <= {8'h00, old_lane};
            end else if (kind_r inside {rbs_pkg::ACC_REG_BIT, rbs_pkg::ACC_MEM_BIT}) begin
                rsp_rdata_r <= {15'h0000, |(ram_rdata & bmask)};
            end else begin
                rsp_rdata_r <= ram_rdata;
            end
        end
    end

    // stack pointer moves
    // A completed push or pop wins over a stack top pointer write in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bbp_r <= `RBS_RST_BANK_BASE;
            sp_r  <= `RBS_RST_STACK_TOP;
            ovl_r <= `RBS_RST_OVF_LIMIT;
            unl_r <= `RBS_RST_UNF_LIMIT;
        end else begin
            if (ptr_wr && ptr_sel == rbs_pkg::PTR_BANK_BASE) bbp_r <= {ptr_wdata[15:1], 1'b0};
            if (ptr_wr && ptr_sel == rbs_pkg::PTR_OVF_LIMIT) ovl_r <= {ptr_wdata[15:1], 1'b0};
            if (ptr_wr && ptr_sel == rbs_pkg::PTR_UNF_LIMIT) unl_r <= {ptr_wdata[15:1], 1'b0};
            if ((state_r == rbs_pkg::ST_MOD) && !refused
                && (kind_r inside {rbs_pkg::ACC_PUSH, rbs_pkg::ACC_POP})) begin
                sp_r <= sp_new_r;
            end else if (ptr_wr && ptr_sel == rbs_pkg::PTR_STACK_TOP) begin
                sp_r <= {ptr_wdata[15:1], 1'b0};
            end
        end
    end

    // Outputs straight from flip-flops
    assign acc_ready         = ready_r;
    assign rsp_valid         = rsp_valid_r;
    assign rsp_rdata         = rsp_rdata_r;
    assign rsp_addr_err      = rsp_err_r;
    assign rsp_sfr_hit       = rsp_sfr_r;
    assign trap_stack_over   = trap_ov_r;
    assign trap_stack_under  = trap_un_r;
    assign bank_base_pointer = bbp_r;
    assign stack_top_pointer = sp_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_answer_two;
        take |-> ##2 rsp_valid;
    endproperty
    a_answer_two: assert property (p_answer_two) else $error("answer not two cycles after take");

    property p_busy_once;
        take |=> !acc_ready ##1 acc_ready;
    endproperty
    a_busy_once: assert property (p_busy_once) else $error("ready not low for one cycle");

    property p_over_cause;
        (take && is_push && (sp_dec < ovl_r)) |-> ##2 trap_stack_over;
    endproperty
    a_over_cause: assert property (p_over_cause) else $error("overflow not trapped");

    property p_under_cause;
        (take && is_pop && (sp_r >= unl_r)) |-> ##2 (trap_stack_under && rsp_valid);
    endproperty
    a_under_cause: assert property (p_under_cause) else $error("underflow not trapped");

    property p_push_moves;
        (take && is_push && !(sp_dec < ovl_r) && !err_now)
            |-> ##2 (sp_r == $past(sp_r, 2) - `RBS_STACK_STEP);
    endproperty
    a_push_moves: assert property (p_push_moves) else $error("push did not lower stack top");

    property p_unmapped;
        (take && is_mem && !in_ram) |-> ##2 (rsp_addr_err && rsp_rdata == 16'h0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_byte_keep;
        (ram_we && kind_r == rbs_pkg::ACC_REG_BYTE) |->
            (hi_r ? ram_wdata[7:0] == ram_rdata[7:0] : ram_wdata[15:8] == ram_rdata[15:8]);
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("byte write spoiled other byte");

    property p_bit_keep;
        (ram_we && kind_r inside {rbs_pkg::ACC_REG_BIT, rbs_pkg::ACC_MEM_BIT}) |->
            (($countones(ram_wdata ^ ram_rdata) <= 1) && ((ram_wdata & ~bmask) == (ram_rdata & ~bmask)));
    endproperty
    a_bit_keep: assert property (p_bit_keep) else $error("bit write touched other bits");

    property p_bit_area;
        (take && acc_kind == rbs_pkg::ACC_MEM_BIT && seg_ok && in_ram && !in_bit) |-> ##2 rsp_addr_err;
    endproperty
    a_bit_area: assert property (p_bit_area) else $error("bit access below bit area taken");

endmodule

// ---- rbs_core_model.sv ----
// Behavioural core pipeline model: issues one access at a time to the
// register bank block and keeps the answer for the bench to inspect.
// Assumes one clk_sys domain and that the bench calls access serially.
`timescale 1ns/10ps

module rbs_core_model (
    input  wire logic          clk_sys,
    output logic               acc_req,
    output rbs_pkg::rbs_kind_t acc_kind,
    output logic               acc_wr,
    output logic [3:0]         acc_reg_num,
    output logic [23:0]        acc_addr,
    output logic [3:0]         acc_bit,
    output logic [15:0]        acc_wdata,
    input  wire logic          acc_ready,
    input  wire logic          rsp_valid,
    input  wire logic [15:0]   rsp_rdata,
    input  wire logic          rsp_addr_err,
    input  wire logic          rsp_sfr_hit,
    input  wire logic          trap_stack_over,
    input  wire logic          trap_stack_under
);
    logic [15:0] got_rdata;
    logic [3:0]  got_flags;
    logic        hung;

    // Idle request lines from time zero
    initial begin
        acc_req     = 1'h0;
        acc_kind    = rbs_pkg::ACC_REG_WORD;
        acc_wr      = 1'h0;
        acc_reg_num = 4'h0;
        acc_addr    = 24'h000000;
        acc_bit     = 4'h0;
        acc_wdata   = 16'h0000;
        hung        = 1'h0;
    end

    // One access: hold until taken, then wait for the one-cycle answer
    task automatic access(input rbs_pkg::rbs_kind_t k, input logic w, input logic [3:0] rn,
                          input logic [23:0] a, input logic [3:0] b, input logic [15:0] d);
        int n;
        @(posedge clk_sys);
        acc_req     <= 1'h1;
        acc_kind    <= k;
        acc_wr      <= w;
        acc_reg_num <= rn;
        acc_addr    <= a;
        acc_bit     <= b;
        acc_wdata   <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (acc_ready !== 1'h1 && n < 20);
        // Released number, address, bit and data lines show the inverse so a stale value is never reused
        acc_req     <= 1'h0;
        acc_reg_num <= ~rn;
        acc_addr    <= ~a;
        acc_bit     <= ~b;
        acc_wdata   <= ~d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp_valid !== 1'h1 && n < 20);
        hung      = hung | (rsp_valid !== 1'h1);
        got_rdata = rsp_rdata;
        got_flags = {rsp_addr_err, rsp_sfr_hit, trap_stack_over, trap_stack_under};
    endtask
endmodule

// ---- register_bank_and_stack_check_test.sv ----
// Self-checking bench for the register bank and stack check block.
// Assumes the core model file is compiled first and the map header is on the path.
`timescale 1ns/10ps
`include "rbs_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module register_bank_and_stack_check_test;
    typedef struct {
        rbs_pkg::rbs_kind_t k;
        logic w; logic [3:0] rn; logic [23:0] a; logic [3:0] b; logic [15:0] d;
        logic ck; logic [15:0] erd; logic [3:0] efl;
    } rbs_row_t;

    logic              clk_sys = 1'h0;
    logic              srst = 1'h1;
    logic              ptr_wr = 1'h0;
    rbs_pkg::rbs_ptr_t ptr_sel = rbs_pkg::PTR_BANK_BASE;
    logic [15:0]       ptr_wdata = 16'h0000;
    logic              acc_req, acc_wr, acc_ready, rsp_valid, rsp_addr_err, rsp_sfr_hit;
    logic              trap_stack_over, trap_stack_under;
    rbs_pkg::rbs_kind_t acc_kind;
    logic [3:0]        acc_reg_num, acc_bit;
    logic [23:0]       acc_addr;
    logic [15:0]       acc_wdata, rsp_rdata, bank_base_pointer, stack_top_pointer;
    int                n_fail = 0;
    int                tests_run = 0;

    // ****************************************************************
    // Ordinary cases: flags are {err, sfr, over, under}
    // ****************************************************************
    rbs_row_t rows [18] = '{
        '{rbs_pkg::ACC_REG_WORD, 1'h1, 4'h1, 24'h0, 4'h0, 16'hA5C3, 1'h0, 16'h0000, 4'h0},
        '{rbs_pkg::ACC_REG_WORD, 1'h0, 4'h1, 24'h0, 4'h0, 16'h0000, 1'h1, 16'hA5C3, 4'h0},
        '{rbs_pkg::ACC_REG_BYTE, 1'h1, 4'h3, 24'h0, 4'h0, 16'h007E, 1'h1, 16'h00A5, 4'h0},
        '{rbs_pkg::ACC_REG_WORD, 1'h0, 4'h1, 24'h0, 4'h0, 16'h0000, 1'h1, 16'h7EC3, 4'h0},
        '{rbs_pkg::ACC_REG_BIT,  1'h1, 4'h1, 24'h0, 4'h4, 16'h0001, 1'h1, 16'h0000, 4'h0},
        '{rbs_pkg::ACC_MEM_WORD, 1'h0, 4'h0, 24'hFC02, 4'h0, 16'h0, 1'h1, 16'h7ED3, 4'h0},
        '{rbs_pkg::ACC_MEM_BYTE, 1'h0, 4'h0, 24'hFC03, 4'h0, 16'h0, 1'h1, 16'h007E, 4'h0},
        '{rbs_pkg::ACC_MEM_WORD, 1'h1, 4'h0, 24'hFD10, 4'h0, 16'h8001, 1'h0, 16'h0, 4'h0},
        '{rbs_pkg::ACC_MEM_BIT,  1'h0, 4'h0, 24'hFD11, 4'h7, 16'h0, 1'h1, 16'h0001, 4'h0},
        '{rbs_pkg::ACC_MEM_BIT,  1'h1, 4'h0, 24'hFD10, 4'h1, 16'h1, 1'h1, 16'h0000, 4'h0},
        '{rbs_pkg::ACC_MEM_WORD, 1'h1, 4'h0, 24'h01FD10, 4'h0, 16'hFFFF, 1'h1, 16'h0, 4'h8},
        '{rbs_pkg::ACC_MEM_WORD, 1'h0, 4'h0, 24'hFD10, 4'h0, 16'h0, 1'h1, 16'h8003, 4'h0},
        '{rbs_pkg::ACC_MEM_BIT,  1'h0, 4'h0, 24'hFCFF, 4'h0, 16'h0, 1'h1, 16'h0000, 4'h8},
        '{rbs_pkg::ACC_MEM_WORD, 1'h0, 4'h0, 24'hFE00, 4'h0, 16'h0, 1'h1, 16'h0000, 4'hC},
        '{rbs_pkg::ACC_MEM_WORD, 1'h0, 4'h0, 24'hF1FE, 4'h0, 16'h0, 1'h1, 16'h0000, 4'hC},
        '{rbs_pkg::ACC_MEM_WORD, 1'h0, 4'h0, 24'hFD11, 4'h0, 16'h0, 1'h1, 16'h0000, 4'h8},
        '{rbs_pkg::ACC_MEM_BYTE, 1'h0, 4'h0, 24'h01FD10, 4'h0, 16'h0, 1'h1, 16'h0000, 4'h8},
        '{rbs_pkg::ACC_MEM_WORD, 1'h1, 4'h0, 24'hFDFE, 4'h0, 16'h1234, 1'h0, 16'h0000, 4'h0}
    };

    // Clock at 25 MHz
    always #20 clk_sys = ~clk_sys;

    rbs_top #(.RAM_AW(10)) dut (.clk_sys(clk_sys), .srst(srst), .ptr_wr(ptr_wr),
        .ptr_sel(ptr_sel), .ptr_wdata(ptr_wdata), .acc_req(acc_req), .acc_kind(acc_kind),
        .acc_wr(acc_wr), .acc_reg_num(acc_reg_num), .acc_addr(acc_addr), .acc_bit(acc_bit),
        .acc_wdata(acc_wdata), .acc_ready(acc_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_addr_err(rsp_addr_err), .rsp_sfr_hit(rsp_sfr_hit),
        .trap_stack_over(trap_stack_over), .trap_stack_under(trap_stack_under),
        .bank_base_pointer(bank_base_pointer), .stack_top_pointer(stack_top_pointer));

    rbs_core_model core (.clk_sys(clk_sys), .acc_req(acc_req), .acc_kind(acc_kind),
        .acc_wr(acc_wr), .acc_reg_num(acc_reg_num), .acc_addr(acc_addr), .acc_bit(acc_bit),
        .acc_wdata(acc_wdata), .acc_ready(acc_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_addr_err(rsp_addr_err), .rsp_sfr_hit(rsp_sfr_hit),
        .trap_stack_over(trap_stack_over), .trap_stack_under(trap_stack_under));

    // Counts, verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One access through the core model, answer compared with the row
    task automatic run(input rbs_row_t r);
        core.access(r.k, r.w, r.rn, r.a, r.b, r.d);
        if (r.ck)
            `CHK("read data", r.erd, core.got_rdata)
        `CHK("answer flags", r.efl, core.got_flags)
    endtask

    // Pointer write, task returns one cycle after the pointer is written
    task automatic ptr(input rbs_pkg::rbs_ptr_t s, input logic [15:0] v);
        @(posedge clk_sys);
        ptr_wr    <= 1'h1;
        ptr_sel   <= s;
        ptr_wdata <= v;
        @(posedge clk_sys);
        ptr_wr    <= 1'h0;
        @(posedge clk_sys);
        #1;
    endtask

    // Watchdog sized well past the expected run
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        test_done();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (7) @(posedge clk_sys);
        #1;
        `CHK("ready in reset", 1'h1, acc_ready)
        // Release on a clock edge so eight edges see reset high
        @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        #1;
        `CHK("bank base reset", `RBS_RST_BANK_BASE, bank_base_pointer)
        `CHK("stack top reset", `RBS_RST_STACK_TOP, stack_top_pointer)
        // function register addresses only read, never written
        foreach (rows[i])
            run(rows[i]);
        // High byte of the last RAM word, written by the final row
        run('{rbs_pkg::ACC_MEM_BYTE, '0, '0, 24'hFDFF, '0, '0, 1'h1, 16'h0012, '0});
        // Shifted bank overlaps the old one; bit0 of the pointer is dropped
        ptr(rbs_pkg::PTR_BANK_BASE, 16'hFC03);
        `CHK("bank base", 16'hFC02, bank_base_pointer)
        run('{rbs_pkg::ACC_REG_WORD, '0, '0, '0, '0, '0, 1'h1, 16'h7ED3, '0});
        run('{rbs_pkg::ACC_REG_BYTE, '0, 4'h1, '0, '0, '0, 1'h1, 16'h007E, '0});
        run('{rbs_pkg::ACC_REG_BIT, '0, '0, '0, 4'h4, '0, 1'h1, 16'h0001, '0});
        // Stack: empty pop, push and pop back, then both overflow sides
        run('{rbs_pkg::ACC_POP, '0, '0, '0, '0, '0, 1'h1, 16'h0000, 4'h1});
        `CHK("sp after refused pop", 16'hFC00, stack_top_pointer)
        run('{rbs_pkg::ACC_PUSH, 1'h1, '0, '0, '0, 16'h1111, 1'h0, '0, '0});
        `CHK("sp after push", 16'hFBFE, stack_top_pointer)
        run('{rbs_pkg::ACC_MEM_WORD, '0, '0, 24'hFBFE, '0, '0, 1'h1, 16'h1111, '0});
        run('{rbs_pkg::ACC_POP, '0, '0, '0, '0, '0, 1'h1, 16'h1111, '0});
        `CHK("sp after pop", 16'hFC00, stack_top_pointer)
        ptr(rbs_pkg::PTR_STACK_TOP, 16'hFA00);
        run('{rbs_pkg::ACC_PUSH, 1'h1, '0, '0, '0, 16'h2222, 1'h1, 16'h0000, 4'h2});
        `CHK("sp after refused push", 16'hFA00, stack_top_pointer)
        ptr(rbs_pkg::PTR_STACK_TOP, 16'hFA02);
        run('{rbs_pkg::ACC_PUSH, 1'h1, '0, '0, '0, 16'h3333, 1'h0, '0, '0});
        `CHK("sp at limit", 16'hFA00, stack_top_pointer)
        // Moved limits: push below the old floor, then pop into the new ceiling
        ptr(rbs_pkg::PTR_OVF_LIMIT, 16'hF9FE);
        ptr(rbs_pkg::PTR_UNF_LIMIT, 16'hFA00);
        run('{rbs_pkg::ACC_PUSH, 1'h1, '0, '0, '0, 16'h4444, 1'h0, '0, '0});
        `CHK("sp after moved limit", 16'hF9FE, stack_top_pointer)
        run('{rbs_pkg::ACC_POP, '0, '0, '0, '0, '0, 1'h1, 16'h4444, '0});
        run('{rbs_pkg::ACC_POP, '0, '0, '0, '0, '0, 1'h1, 16'h0000, 4'h1});
        `CHK("sp after new ceiling", 16'hFA00, stack_top_pointer)
        // Second reset in mid-run restores both pointers
        @(posedge clk_sys);
        srst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'h0;
        #1;
        `CHK("ready rerun", 1'h1, acc_ready)
        `CHK("bank base rerun", `RBS_RST_BANK_BASE, bank_base_pointer)
        `CHK("stack top rerun", `RBS_RST_STACK_TOP, stack_top_pointer)
        // First request right after release; RAM words survive reset
        run('{rbs_pkg::ACC_REG_WORD, '0, 4'h1, '0, '0, '0, 1'h1, 16'h7ED3, '0});
        `CHK("model hang", 1'h0, core.hung)
        test_done();
    end
endmodule
